// ==== hdl/bridge_err_pkg.sv ====
// Shared constants and types for the bridge error capture and acknowledge block
package bridge_err_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [31:0] STATUS_ADDR  = 32'hFEFF0024;
   localparam logic [31:0] ERR_ADDR_ADDR = 32'hFEFF0028;
   localparam logic [31:0] ERR_ATTR_ADDR = 32'hFEFF002C;
   localparam logic [31:0] IACK_ADDR    = 32'hFEFF0030;

   // Reset values
   localparam logic [31:0] WORD_ZERO    = 32'h00000000;
   localparam logic [7:0]  STATUS_RESET = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Status register bit positions
   localparam int BIT_TARGET_ABORT = 0;
   localparam int BIT_MASTER_ABORT = 1;
   localparam int BIT_SYSTEM_ERR   = 2;
   localparam int BIT_PCI_PARITY   = 3;
   localparam int BIT_PROC_PARITY  = 4;
   localparam int BIT_TIMEOUT      = 5;
   localparam int BIT_OVERFLOW     = 7;
   localparam int STATUS_W         = 8;
   localparam logic [7:0] STATUS_MASK  = 8'hBF;  // Bit 6 reserved, reads zero
   localparam logic [7:0] CAPTURE_SRC  = 8'h23;  // Timeout and both aborts
   localparam logic [7:0] PARITY_SRC   = 8'h1C;  // Attribute reads zero
   localparam logic [7:0] ERROR_SRC    = 8'h3F;

   ////////////////////////////////////////////////////////////////////////////////
   // Attribute field layouts
   localparam int ID_W       = 2;
   localparam int TT_W       = 5;
   localparam int SIZE_W     = 3;
   localparam int CMD_W      = 4;
   localparam int LANE_W     = 8;
   localparam int TO_TT_LSB  = 11;
   localparam int TO_SIZE_LSB = 8;
   localparam int TO_BURST   = 7;
   localparam int TO_ID_LSB  = 0;
   localparam int AB_WP      = 15;
   localparam int AB_ID_LSB  = 12;
   localparam int AB_CMD_LSB = 8;
   localparam int AB_LANE_LSB = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus codes and byte lanes
   localparam logic [2:0] HSIZE_BYTE = 3'h0;
   localparam logic [2:0] HSIZE_HALF = 3'h1;
   localparam logic [3:0] LANES_WORD = 4'hF;
   localparam logic [3:0] LANES_LOW  = 4'h3;
   localparam logic [3:0] LANES_HIGH = 4'hC;
   localparam logic [3:0] LANE_ONE   = 4'h1;
   localparam logic       HRESP_OKAY = 1'b0;

   typedef enum logic [0:0] {bus_idle, bus_iack} bus_state_t;

endpackage : bridge_err_pkg

// ==== hdl/capture_reg.sv ====
// Loadable capture register that holds its value between loads
module capture_reg #(
   parameter int              W     = 32,
   parameter logic [W-1:0]    RESET = '0
) (
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          load,
   input  wire logic [W-1:0]  d,
   output logic      [W-1:0]  q
);

   logic [W-1:0] next_q;

   // Take new data on load, otherwise hold
   always_comb begin
      next_q = load ? d : q;
   end

   // Register stage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= RESET;
      end else begin
         q <= next_q;
      end
   end

endmodule : capture_reg

// ==== hdl/iack_engine.sv ====
// Runs one interrupt acknowledge request toward the PCI master and returns its vector
module iack_engine (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        start,
   input  wire logic [3:0]  lanes_in,
   input  wire logic        pci_iack_done,
   input  wire logic        pci_iack_abort,
   input  wire logic [31:0] pci_iack_vector,
   output logic             iack_req,
   output logic      [3:0]  iack_lanes,
   output logic             result_valid,
   output logic      [31:0] result_data
);

   logic        next_req;
   logic [3:0]  next_lanes;
   logic        next_valid;
   logic [31:0] next_data;
   logic        finish;

   // Request holds until the PCI side answers; answers with no request are ignored
   always_comb begin
      finish     = iack_req & (pci_iack_done | pci_iack_abort);
      next_req   = iack_req;
      next_lanes = iack_lanes;
      next_valid = 1'b0;
      next_data  = result_data;
      if (start && !iack_req) begin
         next_req   = 1'b1;
         next_lanes = lanes_in;
      end else if (finish) begin
         next_req   = 1'b0;
         next_valid = 1'b1;
         next_data  = pci_iack_done ? pci_iack_vector : bridge_err_pkg::WORD_ZERO;
      end
   end

   // Register stage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         iack_req     <= 1'b0;
         iack_lanes   <= 4'h0;
         result_valid <= 1'b0;
         result_data  <= bridge_err_pkg::WORD_ZERO;
      end else begin
         iack_req     <= next_req;
         iack_lanes   <= next_lanes;
         result_valid <= next_valid;
         result_data  <= next_data;
      end
   end

endmodule : iack_engine

// ==== hdl/bridge_error_capture_iack.sv ====
// Error address and attribute capture plus interrupt acknowledge, on an AHB-Lite slave
//
// How it works
// - processor timeout flag setting loads the error address with the processor address.
// - master abort or target abort setting loads the error address with the PCI address.
// - parity and system errors leave the error address untouched.
// - any parity or system error flag set makes the attribute read as zero.
// - timeout or abort captures the originating processor master id.
// - the captured master id keeps the global control register's encoding.
// - timeout layout records whether the failing transfer was a burst.
// - timeout layout records the three-bit transfer size code.
// - timeout layout records the five-bit transfer type code.
// - abort layout sets the posted-write flag for errors during posted writes.
// - abort layout records the four-bit PCI command code.
// - abort layout records eight byte-lane selects, one meaning selected.
// - reading the acknowledge register starts exactly one PCI acknowledge; writes do nothing.
// - the read's byte lanes are passed to the PCI acknowledge cycle.
// - the vector from PCI is returned as the read data.
// - the timeout flag sets when the processor bus timer expires.
// - the master abort flag sets when the PCI master signals master abort.
// - the target abort flag sets when the PCI master receives target abort.
module bridge_error_capture_iack (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic      [31:0] hrdata,
   output logic             hresp,
   input  wire logic        proc_timer_expired,
   input  wire logic [31:0] proc_addr,
   input  wire logic [1:0]  proc_master_id,
   input  wire logic        proc_burst,
   input  wire logic [2:0]  proc_size_code,
   input  wire logic [4:0]  proc_type_code,
   input  wire logic        proc_parity_err,
   input  wire logic        pci_master_abort,
   input  wire logic        pci_target_abort,
   input  wire logic [31:0] pci_addr,
   input  wire logic [1:0]  pci_master_id,
   input  wire logic        pci_posted_write,
   input  wire logic [3:0]  pci_cmd,
   input  wire logic [7:0]  pci_lanes,
   input  wire logic        pci_perr_seen,
   input  wire logic        pci_serr_seen,
   input  wire logic        pci_iack_done,
   input  wire logic        pci_iack_abort,
   input  wire logic [31:0] pci_iack_vector,
   output logic             iack_req,
   output logic      [3:0]  iack_lanes
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   bridge_err_pkg::bus_state_t state;
   bridge_err_pkg::bus_state_t next_state;
   logic        next_ready;
   logic [31:0] next_rdata;
   logic        wr_pend;
   logic        next_wr_pend;
   logic        accept;
   logic        iack_start;
   logic [3:0]  lane_pat;
   logic [31:0] read_mux;
   logic [31:0] word_addr;
   logic [7:0]  flags;
   logic [7:0]  next_flags;
   logic [7:0]  set_vec;
   logic [7:0]  clr_vec;
   logic        cap_held;
   logic        to_load;
   logic        ab_load;
   logic [31:0] addr_d;
   logic [31:0] attr_d;
   logic [31:0] to_word;
   logic [31:0] ab_word;
   logic [31:0] err_addr;
   logic [31:0] err_attr;
   logic [31:0] attr_view;
   logic        iack_valid;
   logic [31:0] iack_data;

   ////////////////////////////////////////////////////////////////////////////////
   // Status flags: hardware set wins over a same-cycle write-one clear
   always_comb begin
      set_vec = 8'h00;
      set_vec[bridge_err_pkg::BIT_TIMEOUT]      = proc_timer_expired;
      set_vec[bridge_err_pkg::BIT_MASTER_ABORT] = pci_master_abort;
      set_vec[bridge_err_pkg::BIT_TARGET_ABORT] = pci_target_abort;
      set_vec[bridge_err_pkg::BIT_PROC_PARITY]  = proc_parity_err;
      set_vec[bridge_err_pkg::BIT_PCI_PARITY]   = pci_perr_seen;
      set_vec[bridge_err_pkg::BIT_SYSTEM_ERR]   = pci_serr_seen;
      set_vec[bridge_err_pkg::BIT_OVERFLOW]     =
         (|set_vec) & (|(flags & bridge_err_pkg::ERROR_SRC));
      clr_vec    = wr_pend ? (hwdata[7:0] & bridge_err_pkg::STATUS_MASK) : 8'h00;
      next_flags = ((flags & ~clr_vec) | set_vec) & bridge_err_pkg::STATUS_MASK;
   end

   // Register stage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags <= bridge_err_pkg::STATUS_RESET;
      end else begin
         flags <= next_flags;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Capture selection: a held capture blocks later loads until its flag clears
   always_comb begin
      cap_held = |(flags & ~clr_vec & bridge_err_pkg::CAPTURE_SRC);
      to_load  = proc_timer_expired & ~cap_held;
      ab_load  = (pci_master_abort | pci_target_abort)
                 & ~proc_timer_expired & ~cap_held;
      to_word  = bridge_err_pkg::WORD_ZERO;
      to_word[bridge_err_pkg::TO_TT_LSB +: bridge_err_pkg::TT_W]     = proc_type_code;
      to_word[bridge_err_pkg::TO_SIZE_LSB +: bridge_err_pkg::SIZE_W] = proc_size_code;
      to_word[bridge_err_pkg::TO_BURST]                              = proc_burst;
      to_word[bridge_err_pkg::TO_ID_LSB +: bridge_err_pkg::ID_W]     = proc_master_id;
      ab_word  = bridge_err_pkg::WORD_ZERO;
      ab_word[bridge_err_pkg::AB_WP]                                 = pci_posted_write;
      ab_word[bridge_err_pkg::AB_ID_LSB +: bridge_err_pkg::ID_W]     = pci_master_id;
      ab_word[bridge_err_pkg::AB_CMD_LSB +: bridge_err_pkg::CMD_W]   = pci_cmd;
      ab_word[bridge_err_pkg::AB_LANE_LSB +: bridge_err_pkg::LANE_W] = pci_lanes;
      addr_d   = to_load ? proc_addr : pci_addr;
      attr_d   = to_load ? to_word : ab_word;
   end

   // Address and attribute captures
   capture_reg #(
      .W     (32),
      .RESET (bridge_err_pkg::WORD_ZERO)
   ) u_addr_cap (
      .hclk    (hclk),
      .hresetn (hresetn),
      .load    (to_load | ab_load),
      .d       (addr_d),
      .q       (err_addr)
   );

   capture_reg #(
      .W     (32),
      .RESET (bridge_err_pkg::WORD_ZERO)
   ) u_attr_cap (
      .hclk    (hclk),
      .hresetn (hresetn),
      .load    (to_load | ab_load),
      .d       (attr_d),
      .q       (err_attr)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Read view and lane pattern of the current address phase
   always_comb begin
      // Sub-word accesses decode by their word, so any byte of a register hits it
      word_addr = {haddr[31:2], 2'h0};
      attr_view = (|(flags & bridge_err_pkg::PARITY_SRC)) ?
                  bridge_err_pkg::WORD_ZERO : err_attr;
      unique case (word_addr)
         bridge_err_pkg::STATUS_ADDR:   read_mux = {24'h000000, flags};
         bridge_err_pkg::ERR_ADDR_ADDR: read_mux = err_addr;
         bridge_err_pkg::ERR_ATTR_ADDR: read_mux = attr_view;
         default:                       read_mux = bridge_err_pkg::WORD_ZERO;
      endcase
      if (hsize == bridge_err_pkg::HSIZE_BYTE) begin
         lane_pat = bridge_err_pkg::LANE_ONE << haddr[1:0];
      end else if (hsize == bridge_err_pkg::HSIZE_HALF) begin
         lane_pat = haddr[1] ? bridge_err_pkg::LANES_HIGH : bridge_err_pkg::LANES_LOW;
      end else begin
         lane_pat = bridge_err_pkg::LANES_WORD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus slave: zero-wait for plain registers, stalled for the acknowledge read
   always_comb begin
      accept       = hsel & htrans[1] & hready;
      next_state   = state;
      next_ready   = hreadyout;
      next_rdata   = hrdata;
      next_wr_pend = 1'b0;
      iack_start   = 1'b0;
      unique case (state)
         bridge_err_pkg::bus_idle: begin
            if (accept) begin
               if (hwrite) begin
                  // Only status takes writes; the acknowledge register ignores them
                  next_wr_pend = (word_addr == bridge_err_pkg::STATUS_ADDR);
                  next_rdata   = bridge_err_pkg::WORD_ZERO;
               end else if (word_addr == bridge_err_pkg::IACK_ADDR) begin
                  iack_start   = 1'b1;
                  next_ready   = 1'b0;
                  next_state   = bridge_err_pkg::bus_iack;
               end else begin
                  next_rdata   = read_mux;
               end
            end
         end
         bridge_err_pkg::bus_iack: begin
            if (iack_valid) begin
               next_rdata = iack_data;
               next_ready = 1'b1;
               next_state = bridge_err_pkg::bus_idle;
            end
         end
      endcase
   end

   // Register stage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state     <= bridge_err_pkg::bus_idle;
         hreadyout <= 1'b1;
         hrdata    <= bridge_err_pkg::WORD_ZERO;
         hresp     <= bridge_err_pkg::HRESP_OKAY;
         wr_pend   <= 1'b0;
      end else begin
         state     <= next_state;
         hreadyout <= next_ready;
         hrdata    <= next_rdata;
         hresp     <= bridge_err_pkg::HRESP_OKAY;
         wr_pend   <= next_wr_pend;
      end
   end

   // Acknowledge cycle toward the PCI master
   iack_engine u_iack (
      .hclk            (hclk),
      .hresetn         (hresetn),
      .start           (iack_start),
      .lanes_in        (lane_pat),
      .pci_iack_done   (pci_iack_done),
      .pci_iack_abort  (pci_iack_abort),
      .pci_iack_vector (pci_iack_vector),
      .iack_req        (iack_req),
      .iack_lanes      (iack_lanes),
      .result_valid    (iack_valid),
      .result_data     (iack_data)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   property p_timeout_addr;
      to_load |=> err_addr == $past(proc_addr);
   endproperty
   a_timeout_addr: assert property (p_timeout_addr) else $error("timeout address not captured");

   property p_abort_addr;
      (pci_master_abort || pci_target_abort) && !proc_timer_expired && !cap_held
         |=> err_addr == $past(pci_addr);
   endproperty
   a_abort_addr: assert property (p_abort_addr) else $error("abort address not captured");

   property p_parity_zero;
      (|(flags & bridge_err_pkg::PARITY_SRC)) && accept && !hwrite
         && haddr == bridge_err_pkg::ERR_ATTR_ADDR |=> hrdata == bridge_err_pkg::WORD_ZERO;
   endproperty
   a_parity_zero: assert property (p_parity_zero) else $error("attribute not zero");

   property p_timeout_fields;
      to_load |=> err_attr[bridge_err_pkg::TO_ID_LSB +: bridge_err_pkg::ID_W]
                     == $past(proc_master_id)
               && err_attr[bridge_err_pkg::TO_BURST] == $past(proc_burst)
               && err_attr[bridge_err_pkg::TO_SIZE_LSB +: bridge_err_pkg::SIZE_W]
                     == $past(proc_size_code);
   endproperty
   a_timeout_fields: assert property (p_timeout_fields) else $error("timeout fields wrong");

   property p_timeout_type;
      to_load |=> err_attr[bridge_err_pkg::TO_TT_LSB +: bridge_err_pkg::TT_W]
                     == $past(proc_type_code);
   endproperty
   a_timeout_type: assert property (p_timeout_type) else $error("transfer type wrong");

   property p_abort_fields;
      ab_load |=> err_attr[bridge_err_pkg::AB_WP] == $past(pci_posted_write)
               && err_attr[bridge_err_pkg::AB_CMD_LSB +: bridge_err_pkg::CMD_W] == $past(pci_cmd)
               && err_attr[bridge_err_pkg::AB_LANE_LSB +: bridge_err_pkg::LANE_W]
                     == $past(pci_lanes);
   endproperty
   a_abort_fields: assert property (p_abort_fields) else $error("abort fields wrong");

   property p_one_iack;
      $rose(iack_req) |-> state == bridge_err_pkg::bus_iack
                          && $past(state) == bridge_err_pkg::bus_idle;
   endproperty
   a_one_iack: assert property (p_one_iack) else $error("stray acknowledge request");

   property p_iack_lanes;
      iack_start |=> iack_req && iack_lanes == $past(lane_pat);
   endproperty
   a_iack_lanes: assert property (p_iack_lanes) else $error("acknowledge lanes wrong");

   property p_vector;
      iack_req && pci_iack_done |=> ##1 hreadyout && hrdata == $past(pci_iack_vector, 2);
   endproperty
   a_vector: assert property (p_vector) else $error("vector not returned");

   property p_flags_set;
      proc_timer_expired || pci_master_abort || pci_target_abort
         |=> (flags[bridge_err_pkg::BIT_TIMEOUT] || !$past(proc_timer_expired))
             && (flags[bridge_err_pkg::BIT_MASTER_ABORT] || !$past(pci_master_abort))
             && (flags[bridge_err_pkg::BIT_TARGET_ABORT] || !$past(pci_target_abort));
   endproperty
   a_flags_set: assert property (p_flags_set) else $error("flag not set");

   property p_hold;
      cap_held |=> $stable(err_addr) && $stable(err_attr);
   endproperty
   a_hold: assert property (p_hold) else $error("capture changed while held");

   property p_stall;
      state == bridge_err_pkg::bus_iack |-> !hreadyout;
   endproperty
   a_stall: assert property (p_stall) else $error("acknowledge read not stalled");

   c_timeout: cover property (to_load ##1 cap_held);
   c_abort: cover property (ab_load);
   c_iack: cover property (iack_start ##[1:50] iack_valid);

endmodule : bridge_error_capture_iack

// ==== verification/pci_iack_model.sv ====
// Far-side model that answers interrupt acknowledge requests from the bridge
module pci_iack_model (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        iack_req,
   input  wire logic [3:0]  delay,
   input  wire logic        do_abort,
   input  wire logic [31:0] vector,
   output logic             pci_iack_done,
   output logic             pci_iack_abort,
   output logic      [31:0] pci_iack_vector
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [3:0] cnt;
   logic       fin;
   logic       ans;

   ////////////////////////////////////////////////////////////////////////////////
   // Wait the chosen cycles, then end each request exactly once
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 4'h0;
         fin <= 1'b0;
         ans <= 1'b0;
      end else if (!iack_req) begin
         cnt <= 4'h0;
         fin <= 1'b0;
         ans <= 1'b0;
      end else if (!ans && cnt >= delay) begin
         fin <= 1'b1;
         ans <= 1'b1;
      end else begin
         fin <= 1'b0;
         cnt <= cnt + 4'h1;
      end
   end

   // Vector is valid only with done; otherwise the lines show a changed pattern
   assign pci_iack_done   = fin & ~do_abort;
   assign pci_iack_abort  = fin & do_abort;
   assign pci_iack_vector = pci_iack_done ? vector : ~vector;

endmodule : pci_iack_model

// ==== verification/bridge_error_capture_iack_tb.sv ====
// Self-checking bench for the error capture and acknowledge block
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module bridge_error_capture_iack_tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic        hclk, hresetn, hsel, hwrite, proc_burst, pci_posted_write, do_abort;
   logic        hreadyout, hresp, iack_req, done_w, abort_w, req_q;
   logic [31:0] haddr, hwdata, hrdata, proc_addr, pci_addr, vector, ivec, rd;
   logic [1:0]  htrans, proc_master_id, pci_master_id;
   logic [2:0]  hsize, proc_size_code;
   logic [4:0]  proc_type_code;
   logic [3:0]  pci_cmd, delay, iack_lanes, seen_lanes;
   logic [7:0]  pci_lanes;
   logic [5:0]  ev;
   int          miscompares, samples_checked, req_count, n0;
   logic [31:0] ia [5] = '{32'hFEFF0030, 32'hFEFF0030, 32'hFEFF0032, 32'hFEFF0031, 32'hFEFF0033};
   logic [2:0]  is [5] = '{3'h2, 3'h1, 3'h1, 3'h0, 3'h0};
   logic [3:0]  il [5] = '{4'hF, 4'h3, 4'hC, 4'h2, 4'h8};
   logic [3:0]  id [5] = '{4'h0, 4'h3, 4'h1, 4'h5, 4'h2};

   ////////////////////////////////////////////////////////////////////////////////
   // Clock
   always #50 hclk = ~hclk;

   bridge_error_capture_iack dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .proc_timer_expired(ev[0]),
      .proc_addr(proc_addr), .proc_master_id(proc_master_id), .proc_burst(proc_burst),
      .proc_size_code(proc_size_code), .proc_type_code(proc_type_code),
      .proc_parity_err(ev[1]), .pci_master_abort(ev[4]), .pci_target_abort(ev[5]),
      .pci_addr(pci_addr), .pci_master_id(pci_master_id), .pci_posted_write(pci_posted_write),
      .pci_cmd(pci_cmd), .pci_lanes(pci_lanes), .pci_perr_seen(ev[2]), .pci_serr_seen(ev[3]),
      .pci_iack_done(done_w), .pci_iack_abort(abort_w), .pci_iack_vector(ivec),
      .iack_req(iack_req), .iack_lanes(iack_lanes));

   pci_iack_model model_u (.hclk(hclk), .hresetn(hresetn), .iack_req(iack_req), .delay(delay),
      .do_abort(do_abort), .vector(vector), .pci_iack_done(done_w), .pci_iack_abort(abort_w),
      .pci_iack_vector(ivec));

   // Count acknowledge requests and keep their lanes
   always @(posedge hclk) begin
      req_q <= iack_req;
      if (iack_req) seen_lanes <= iack_lanes;
      if (iack_req && !req_q) req_count <= req_count + 1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Closing report
   task automatic end_sim;
      $display("COUNTS samples_checked=%0d miscompares=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim

   // Wait for hready sampled high, bounded
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      if (hreadyout !== 1'b1) begin
         miscompares++;
         end_sim();
      end
   endtask : wait_ready

   // One single AHB-Lite transfer, read data left in rd
   task automatic ahb(input logic w, input logic [31:0] a, input logic [2:0] s,
                      input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsize <= s;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : ahb

   // One-cycle event pulse
   task automatic pulse(input int i);
      ev[i] <= 1'b1;
      @(posedge hclk);
      ev <= 6'h00;
      @(posedge hclk);
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {hclk, hresetn, hsel, hwrite, proc_burst, pci_posted_write, do_abort} = 7'h00;
      {haddr, hwdata, proc_addr, pci_addr, vector} = '0;
      {htrans, proc_master_id, pci_master_id, hsize, proc_size_code, proc_type_code} = '0;
      {pci_cmd, delay, pci_lanes, ev} = '0;
      {miscompares, samples_checked, req_count} = '0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (ia[k]) begin
         ahb(1'b1, bridge_err_pkg::ERR_ADDR_ADDR + 32'(k % 2 * 4), 3'h2, 32'hFFFFFFFF);
         ahb(1'b0, bridge_err_pkg::ERR_ADDR_ADDR + 32'(k * 4 % 16), 3'h2, 32'h0);
         `CHK(rd, bridge_err_pkg::WORD_ZERO)
      end
      $display("test reset done");
      proc_addr <= 32'hA5A51234;
      proc_master_id <= 2'h2;
      proc_burst <= 1'b1;
      proc_size_code <= 3'h5;
      proc_type_code <= 5'h1A;
      pci_addr <= 32'h0BAD0000;
      pulse(0);
      pulse(4);
      ahb(1'b0, bridge_err_pkg::ERR_ADDR_ADDR, 3'h2, 32'h0);
      `CHK(rd, 32'hA5A51234)
      ahb(1'b0, bridge_err_pkg::ERR_ATTR_ADDR, 3'h2, 32'h0);
      `CHK(rd, {16'h0000, 5'h1A, 3'h5, 1'b1, 5'h00, 2'h2})
      ahb(1'b0, bridge_err_pkg::STATUS_ADDR, 3'h2, 32'h0);
      `CHK(rd, 32'h000000A2)
      ahb(1'b1, bridge_err_pkg::STATUS_ADDR, 3'h2, 32'h000000FF);
      $display("test timeout done");
      for (int i = 1; i < 4; i++) begin
         pulse(i);
         ahb(1'b0, bridge_err_pkg::ERR_ATTR_ADDR, 3'h2, 32'h0);
         `CHK(rd, bridge_err_pkg::WORD_ZERO)
         ahb(1'b0, bridge_err_pkg::ERR_ADDR_ADDR, 3'h2, 32'h0);
         `CHK(rd, 32'hA5A51234)
         ahb(1'b1, bridge_err_pkg::STATUS_ADDR, 3'h2, 32'h000000FF);
      end
      $display("test parity done");
      for (int i = 4; i < 6; i++) begin
         pci_addr <= 32'hC0000010 + 32'(i);
         pci_master_id <= 2'(i);
         pci_posted_write <= (i == 4);
         pci_cmd <= 4'(i + 7);
         pci_lanes <= 8'h0F << (i - 4);
         pulse(i);
         ahb(1'b0, bridge_err_pkg::ERR_ADDR_ADDR, 3'h2, 32'h0);
         `CHK(rd, pci_addr)
         ahb(1'b0, bridge_err_pkg::ERR_ATTR_ADDR, 3'h2, 32'h0);
         `CHK(rd, {16'h0000, pci_posted_write, 1'b0, pci_master_id, pci_cmd, pci_lanes})
         ahb(1'b0, bridge_err_pkg::STATUS_ADDR, 3'h2, 32'h0);
         `CHK(rd, 32'(1 << (5 - i)))
         ahb(1'b1, bridge_err_pkg::STATUS_ADDR, 3'h2, 32'h000000FF);
      end
      $display("test abort done");
      foreach (ia[k]) begin
         delay <= id[k];
         do_abort <= (k == 4);
         vector <= 32'h5A00C300 + 32'(k);
         n0 = req_count;
         ahb(1'b0, ia[k], is[k], 32'h0);
         `CHK(rd, (k == 4) ? 32'h0 : vector)
         `CHK(seen_lanes, il[k])
         `CHK(req_count - n0, 1)
         `CHK(hresp, bridge_err_pkg::HRESP_OKAY)
      end
      n0 = req_count;
      ahb(1'b1, bridge_err_pkg::IACK_ADDR, 3'h2, 32'hFFFFFFFF);
      repeat (3) @(posedge hclk);
      `CHK(req_count - n0, 0)
      $display("test acknowledge done");
      end_sim();
   end

endmodule : bridge_error_capture_iack_tb
